//--- verilog/afm_regs.svh
// Constants for the audio/video fault monitor and input switch
`ifndef AFM_REGS_SVH
`define AFM_REGS_SVH

`define AFM_CLK_HZ          10000000
`define AFM_SAMPLE_RATE_HZ  48000
`define AFM_HOLD_STEP_MS    500
`define AFM_RELEASE_SEC     1
`define AFM_WIN_LAST        6'h3f
`define AFM_HOLD_MIN        8'h01
`define AFM_HOLD_MAX        8'hfe
`define AFM_HOLD_DEFAULT    8'h14
`define AFM_APH_MIN         7'h32
`define AFM_APH_MAX         7'h64
`define AFM_APH_DEFAULT     7'h5a
`define AFM_MONO_MIN        7'h14
`define AFM_MONO_MAX        7'h32
`define AFM_MONO_DEFAULT    7'h14
`define AFM_PCT_SCALE       32'h00000064
`define AFM_GLITCH_MAX      10'h384
`define AFM_ROUTE_PRIMARY   1'b0

`endif

//--- verilog/afm_pkg.sv
// Types shared by the fault monitor modules
package afm_pkg;

    typedef enum logic [1:0] {
        afm_auto_revert_primary,
        afm_gpi_driven_switching,
        afm_auto_follow_live
    } afm_policy_t;

    typedef enum logic {
        afm_tmr_watch,
        afm_tmr_fault
    } afm_tmr_state_t;

endpackage : afm_pkg

//--- verilog/afm_fault_timer.sv
// Persistence timer: raise after a hold time, drop after a release time
`timescale 1ns/1ns
module afm_fault_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Counting control
    input  wire logic        tick,
    input  wire logic        pause,
    input  wire logic        clear,
    input  wire logic        cond,
    input  wire logic [23:0] hold_cnt,
    input  wire logic [23:0] release_cnt,
    // Result
    output logic             fault
);
    afm_pkg::afm_tmr_state_t state_reg, state_next;
    logic [23:0]             cnt_reg,   cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (clear) begin
            state_next = afm_pkg::afm_tmr_watch;
            cnt_next   = 24'h000000;
        end else if (tick && !pause) begin
            case (state_reg)
                afm_pkg::afm_tmr_watch: begin
                    if (!cond) begin
                        cnt_next = 24'h000000;
                    end else if ((cnt_reg + 24'h000001) >= hold_cnt) begin
                        state_next = afm_pkg::afm_tmr_fault;
                        cnt_next   = 24'h000000;
                    end else begin
                        cnt_next = cnt_reg + 24'h000001;
                    end
                end
                default: begin
                    // Release needs the condition gone without a break
                    if (cond) begin
                        cnt_next = 24'h000000;
                    end else if ((cnt_reg + 24'h000001) >= release_cnt) begin
                        state_next = afm_pkg::afm_tmr_watch;
                        cnt_next   = 24'h000000;
                    end else begin
                        cnt_next = cnt_reg + 24'h000001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= afm_pkg::afm_tmr_watch;
            cnt_reg   <= 24'h000000;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign fault = (state_reg == afm_pkg::afm_tmr_fault);

endmodule : afm_fault_timer

//--- verilog/afm_video_glitch.sv
// Video loss detector that rides through short glitches
`timescale 1ns/1ns
`include "afm_regs.svh"
module afm_video_glitch (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Frame pacing and synchronised presence
    input  wire logic       frame_tick,
    input  wire logic       present,
    input  wire logic [9:0] window,
    // Result
    output logic            lost
);
    logic [9:0] cnt_reg,  cnt_next;
    logic       lost_reg, lost_next;
    logic [9:0] win_lim;

    always_comb begin
        win_lim   = (window > `AFM_GLITCH_MAX) ? `AFM_GLITCH_MAX : window;
        cnt_next  = cnt_reg;
        lost_next = lost_reg;
        if (frame_tick) begin
            if (present) begin
                cnt_next  = 10'h000;
                lost_next = 1'b0;
            end else if (cnt_reg >= win_lim) begin
                lost_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg  <= 10'h000;
            lost_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lost_reg <= lost_next;
        end
    end

    assign lost = lost_reg;

endmodule : afm_video_glitch

//--- verilog/afm_monitor_switch.sv
// Audio/video fault monitor with program and preview routing policy
`timescale 1ns/1ns
`include "afm_regs.svh"
module afm_monitor_switch #(
    parameter int unsigned SAMPLES_PER_SEC = `AFM_SAMPLE_RATE_HZ
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Video presence pins and reference frame pulse
    input  wire logic [1:0]             video_present,
    input  wire logic                   frame_tick,
    // General purpose input contacts
    input  wire logic [1:0]             gpi,
    // De-embedded audio, pair index = input * 2 + pair
    input  wire logic [1:0]             audio_valid,
    input  wire logic [3:0][15:0]       audio_left,
    input  wire logic [3:0][15:0]       audio_right,
    // Fault settings per input
    input  wire logic [1:0][15:0]       silence_level,
    input  wire logic [1:0][7:0]        silence_hold_time,
    input  wire logic [1:0][6:0]        antiphase_threshold,
    input  wire logic [1:0][7:0]        antiphase_hold_time,
    input  wire logic [1:0][6:0]        mono_threshold,
    input  wire logic [1:0][7:0]        mono_hold_time,
    input  wire logic [1:0][9:0]        video_glitch_ignore_time,
    // Routing policy
    input  wire afm_pkg::afm_policy_t   switch_policy,
    // Fault flags
    output logic [1:0]                  video_fault,
    output logic [3:0]                  silence_fault,
    output logic [3:0]                  antiphase_fault,
    output logic [3:0]                  mono_fault,
    // Routing, 0 selects input 1
    output logic [2:0]                  program_route,
    output logic                        preview_route
);
    localparam logic [23:0] HALF_CNT =
        24'(SAMPLES_PER_SEC * `AFM_HOLD_STEP_MS / 1000);
    localparam logic [23:0] REL_CNT  = 24'(SAMPLES_PER_SEC * `AFM_RELEASE_SEC);

    // Half-second steps clamped to 0.5..127 s, turned into sample counts
    function automatic logic [23:0] hold_samples(input logic [7:0] steps);
        logic [7:0] s;
        s = steps;
        if (s < `AFM_HOLD_MIN) begin
            s = `AFM_HOLD_MIN;
        end else if (s > `AFM_HOLD_MAX) begin
            s = `AFM_HOLD_MAX;
        end
        return 24'(32'(s) * 32'(HALF_CNT));
    endfunction : hold_samples

    function automatic logic [6:0] clamp_pct(input logic [6:0] v,
                                             input logic [6:0] lo,
                                             input logic [6:0] hi);
        logic [6:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp_pct

    function automatic logic [16:0] mag17(input logic signed [16:0] v);
        return v[16] ? 17'(-v) : 17'(v);
    endfunction : mag17

    // Pin synchronisers
    logic [1:0] vid_meta_reg, vid_sync_reg;
    logic [1:0] gpi_meta_reg, gpi_sync_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            // Assume presence until the pins have been sampled
            vid_meta_reg <= 2'h3;
            vid_sync_reg <= 2'h3;
            gpi_meta_reg <= 2'h0;
            gpi_sync_reg <= 2'h0;
        end else begin
            vid_meta_reg <= video_present;
            vid_sync_reg <= vid_meta_reg;
            gpi_meta_reg <= gpi;
            gpi_sync_reg <= gpi_meta_reg;
        end
    end

    // Video loss per input
    for (genvar i = 0; i < 2; i++) begin : g_video
        afm_video_glitch u_glitch (
            .clk        (clk),
            .rst        (rst),
            .frame_tick (frame_tick),
            .present    (vid_sync_reg[i]),
            .window     (video_glitch_ignore_time[i]),
            .lost       (video_fault[i])
        );
    end

    // Audio pair analysis
    for (genvar p = 0; p < 4; p++) begin : g_pair
        localparam int IN = p / 2;

        logic signed [16:0] s_diff, s_sum;
        logic [16:0]        m_diff, m_sum;
        logic [15:0]        m_l, m_r;
        logic [22:0]        acc_d_reg, acc_d_next, acc_s_reg, acc_s_next;
        logic [22:0]        tot_d, tot_s;
        logic [15:0]        pk_l_reg, pk_l_next, pk_r_reg, pk_r_next;
        logic [5:0]         win_reg, win_next;
        logic               silent_reg, silent_next;
        logic               aph_reg, aph_next;
        logic               mono_reg, mono_next;
        logic [31:0]        lhs, rhs_aph, rhs_mono;
        logic               l_quiet, r_quiet;
        logic [6:0]         aph_thr, mono_thr;
        logic [23:0]        sil_cnt, aph_cnt, mono_cnt;

        always_comb begin
            s_diff = $signed({audio_left[p][15], audio_left[p]})
                   - $signed({audio_right[p][15], audio_right[p]});
            s_sum  = $signed({audio_left[p][15], audio_left[p]})
                   + $signed({audio_right[p][15], audio_right[p]});
            m_diff = mag17(s_diff);
            m_sum  = mag17(s_sum);
            m_l    = 16'(mag17($signed({audio_left[p][15], audio_left[p]})));
            m_r    = 16'(mag17($signed({audio_right[p][15], audio_right[p]})));
            tot_d  = acc_d_reg + 23'(m_diff);
            tot_s  = acc_s_reg + 23'(m_sum);
            aph_thr  = clamp_pct(antiphase_threshold[IN], `AFM_APH_MIN, `AFM_APH_MAX);
            mono_thr = clamp_pct(mono_threshold[IN], `AFM_MONO_MIN, `AFM_MONO_MAX);
            // Hold times in samples
            sil_cnt  = hold_samples(silence_hold_time[IN]);
            aph_cnt  = hold_samples(antiphase_hold_time[IN]);
            mono_cnt = hold_samples(mono_hold_time[IN]);

            // Measure = diff / (diff + sum): inverted 1, one channel 0.5, equal 0
            lhs      = 32'(tot_d) * `AFM_PCT_SCALE;
            rhs_aph  = 32'(aph_thr) * (32'(tot_d) + 32'(tot_s));
            rhs_mono = 32'(mono_thr) * (32'(tot_d) + 32'(tot_s));
            l_quiet  = ((m_l > pk_l_reg) ? m_l : pk_l_reg) < silence_level[IN];
            r_quiet  = ((m_r > pk_r_reg) ? m_r : pk_r_reg) < silence_level[IN];

            acc_d_next  = acc_d_reg;
            acc_s_next  = acc_s_reg;
            pk_l_next   = pk_l_reg;
            pk_r_next   = pk_r_reg;
            win_next    = win_reg;
            silent_next = silent_reg;
            aph_next    = aph_reg;
            mono_next   = mono_reg;
            // Conditions are judged once per 64-sample window
            if (audio_valid[IN]) begin
                if (win_reg == `AFM_WIN_LAST) begin
                    silent_next = l_quiet && r_quiet;
                    aph_next    = lhs > rhs_aph;
                    // Identical channels, or exactly one channel quiet
                    mono_next   = (lhs <= rhs_mono && tot_s != 23'h000000)
                                || (l_quiet != r_quiet);
                    acc_d_next  = 23'h000000;
                    acc_s_next  = 23'h000000;
                    pk_l_next   = 16'h0000;
                    pk_r_next   = 16'h0000;
                    win_next    = 6'h00;
                end else begin
                    acc_d_next = tot_d;
                    acc_s_next = tot_s;
                    pk_l_next  = (m_l > pk_l_reg) ? m_l : pk_l_reg;
                    pk_r_next  = (m_r > pk_r_reg) ? m_r : pk_r_reg;
                    win_next   = win_reg + 6'h01;
                end
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                acc_d_reg  <= 23'h000000;
                acc_s_reg  <= 23'h000000;
                pk_l_reg   <= 16'h0000;
                pk_r_reg   <= 16'h0000;
                win_reg    <= 6'h00;
                silent_reg <= 1'b0;
                aph_reg    <= 1'b0;
                mono_reg   <= 1'b0;
            end else begin
                acc_d_reg  <= acc_d_next;
                acc_s_reg  <= acc_s_next;
                pk_l_reg   <= pk_l_next;
                pk_r_reg   <= pk_r_next;
                win_reg    <= win_next;
                silent_reg <= silent_next;
                aph_reg    <= aph_next;
                mono_reg   <= mono_next;
            end
        end

        // Hold times count audio samples
        afm_fault_timer u_silence (
            .clk         (clk),
            .rst         (rst),
            .tick        (audio_valid[IN]),
            .pause       (1'b0),
            .clear       (1'b0),
            .cond        (silent_reg),
            .hold_cnt    (sil_cnt),
            .release_cnt (REL_CNT),
            .fault       (silence_fault[p])
        );

        // Silent windows neither advance nor break the phase analysis
        afm_fault_timer u_antiphase (
            .clk         (clk),
            .rst         (rst),
            .tick        (audio_valid[IN]),
            .pause       (silent_reg),
            .clear       (1'b0),
            .cond        (aph_reg),
            .hold_cnt    (aph_cnt),
            .release_cnt (REL_CNT),
            .fault       (antiphase_fault[p])
        );

        afm_fault_timer u_mono (
            .clk         (clk),
            .rst         (rst),
            .tick        (audio_valid[IN]),
            .pause       (silent_reg),
            .clear       (antiphase_fault[p]),
            .cond        (mono_reg),
            .hold_cnt    (mono_cnt),
            .release_cnt (REL_CNT),
            .fault       (mono_fault[p])
        );
    end

    // Routing policy
    logic       force_one, force_two;
    logic [1:0] live;
    logic       route_reg, route_next;
    logic [2:0] pgm_reg, pgm_next;
    logic       prv_reg, prv_next;

    always_comb begin
        // Equal GPI levels force nothing
        force_one  = gpi_sync_reg[0] && !gpi_sync_reg[1];
        force_two  = gpi_sync_reg[1] && !gpi_sync_reg[0];
        live       = ~video_fault;
        route_next = route_reg;
        case (switch_policy)
            afm_pkg::afm_auto_revert_primary: begin
                if (force_one) begin
                    route_next = 1'b0;
                end else if (force_two) begin
                    route_next = 1'b1;
                end else if (live[0]) begin
                    route_next = `AFM_ROUTE_PRIMARY;
                end else if (live[1]) begin
                    route_next = 1'b1;
                end
            end
            afm_pkg::afm_gpi_driven_switching: begin
                if (force_one) begin
                    route_next = 1'b0;
                end else if (force_two) begin
                    route_next = 1'b1;
                end
            end
            afm_pkg::afm_auto_follow_live: begin
                if (!live[route_reg] && live[!route_reg]) begin
                    route_next = !route_reg;
                end
            end
            default: begin
                route_next = route_reg;
            end
        endcase

        // Program outputs move as one; preview takes the other input
        pgm_next   = {3{route_next}};
        prv_next   = !route_next;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            route_reg <= `AFM_ROUTE_PRIMARY;
            pgm_reg   <= 3'h0;
            prv_reg   <= 1'b1;
        end else begin
            route_reg <= route_next;
            pgm_reg   <= pgm_next;
            prv_reg   <= prv_next;
        end
    end

    assign program_route = pgm_reg;
    assign preview_route = prv_reg;

endmodule : afm_monitor_switch

//--- verif/afm_monitor_switch_checker.sv
// Concurrent checks on the ports of the fault monitor and input switch
`timescale 1ns/1ns
module afm_monitor_switch_checker #(
    parameter int unsigned SAMPLES_PER_SEC = 48000
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Stimulus side
    input wire logic                 frame_tick,
    input wire logic [1:0]           gpi,
    input wire logic [1:0]           audio_valid,
    input wire afm_pkg::afm_policy_t switch_policy,
    // Results
    input wire logic [1:0]           video_fault,
    input wire logic [3:0]           silence_fault,
    input wire logic [3:0]           antiphase_fault,
    input wire logic [3:0]           mono_fault,
    input wire logic [2:0]           program_route,
    input wire logic                 preview_route
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_route_equal;
        program_route == 3'h0 || program_route == 3'h7;
    endproperty
    property p_preview_inverse;
        preview_route == !program_route[0];
    endproperty
    property p_mono_suppressed;
        (antiphase_fault & $past(antiphase_fault) & mono_fault) == 4'h0;
    endproperty
    property p_audio_paced;
        ($changed({silence_fault[1:0], antiphase_fault[1:0]}) |-> $past(audio_valid[0])) and
        ($changed({silence_fault[3:2], antiphase_fault[3:2]}) |-> $past(audio_valid[1]));
    endproperty
    property p_video_paced;
        $changed(video_fault) |-> $past(frame_tick);
    endproperty
    property p_force_one;
        (switch_policy == afm_pkg::afm_auto_revert_primary && gpi == 2'h1)[*5]
            |-> program_route == 3'h0;
    endproperty
    property p_force_two;
        (switch_policy == afm_pkg::afm_auto_revert_primary && gpi == 2'h2)[*5]
            |-> program_route == 3'h7;
    endproperty
    property p_manual_hold;
        (switch_policy == afm_pkg::afm_gpi_driven_switching && gpi[0] == gpi[1])[*5]
            |=> $stable(program_route);
    endproperty
    property p_revert_home;
        (switch_policy == afm_pkg::afm_auto_revert_primary && gpi[0] == gpi[1]
            && !video_fault[0])[*5] |-> program_route == 3'h0;
    endproperty
    property p_follow_live;
        (switch_policy == afm_pkg::afm_auto_follow_live && video_fault == 2'h1)[*5]
            |-> program_route == 3'h7;
    endproperty

    a_route_equal: assert property (p_route_equal)
        else $error("program outputs disagree");
    a_preview_inverse: assert property (p_preview_inverse)
        else $error("preview not opposite to program");
    a_mono_suppressed: assert property (p_mono_suppressed)
        else $error("mono flag beside phase flag");
    a_audio_paced: assert property (p_audio_paced)
        else $error("audio flag moved without a sample");
    a_video_paced: assert property (p_video_paced)
        else $error("video flag moved without a frame");
    a_force_one: assert property (p_force_one)
        else $error("contact one did not force input 1");
    a_force_two: assert property (p_force_two)
        else $error("contact two did not force input 2");
    a_manual_hold: assert property (p_manual_hold)
        else $error("manual route moved with equal contacts");
    a_revert_home: assert property (p_revert_home)
        else $error("route did not return to input 1");
    a_follow_live: assert property (p_follow_live)
        else $error("route did not follow live input");

    c_silence: cover property ($rose(silence_fault[0]));
    c_phase: cover property ($rose(antiphase_fault[0]));
    c_mono: cover property ($rose(mono_fault[0]));
endmodule : afm_monitor_switch_checker

bind afm_monitor_switch afm_monitor_switch_checker #(.SAMPLES_PER_SEC(SAMPLES_PER_SEC))
    afm_monitor_switch_checker_i (.clk(clk), .rst(rst), .frame_tick(frame_tick), .gpi(gpi),
    .audio_valid(audio_valid), .switch_policy(switch_policy), .video_fault(video_fault),
    .silence_fault(silence_fault), .antiphase_fault(antiphase_fault),
    .mono_fault(mono_fault), .program_route(program_route), .preview_route(preview_route));

//--- verif/afm_av_source.sv
// Model of the two video feeds, their embedded audio and the contacts
`timescale 1ns/1ns
module afm_av_source (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Scenario controls
    input  wire logic [1:0]      video_on,
    input  wire logic [1:0]      contact,
    input  wire logic [1:0][2:0] mode,
    input  wire logic [15:0]     noise,
    // Pins towards the monitor
    output logic [1:0]           video_present,
    output logic                 frame_tick,
    output logic [1:0]           gpi,
    output logic [1:0]           audio_valid,
    output logic [3:0][15:0]     audio_left,
    output logic [3:0][15:0]     audio_right
);
    logic [4:0]  phase;
    logic [15:0] amp;

    // Fresh amplitude each cycle, always well above the silence level
    assign amp = {4'h1, noise[11:0]};

    always @(posedge clk) begin
        phase <= (rst || phase == 5'h13) ? 5'h00 : phase + 5'h01;
        frame_tick <= !rst && phase == 5'h13;
        audio_valid <= rst ? 2'h0 : {phase[1:0] == 2'h3, phase[1:0] == 2'h1};
        video_present <= video_on;
        gpi <= contact;
        for (int p = 0; p < 4; p++) begin
            audio_left[p] <= (mode[p/2] == 3'h3) ? 16'h0000 : amp;
            case (mode[p/2])
                3'h0: audio_right[p] <= 16'h0000 - (amp >> 2);
                3'h1: audio_right[p] <= 16'h0000 - amp;
                3'h2: audio_right[p] <= amp;
                default: audio_right[p] <= 16'h0000;
            endcase
        end
    end
endmodule : afm_av_source

//--- verif/afm_monitor_switch_bench.sv
// Self-checking bench for the fault monitor and input switch
`timescale 1ns/1ns
module afm_monitor_switch_bench;
    typedef struct {logic [17:0] val; logic [17:0] mask; int dl; bit exact;} afm_note_t;
    logic                 clk, rst, frame_tick, prev;
    logic [1:0]           video_on, contact, video_present, gpi, audio_valid, video_fault;
    logic [1:0][2:0]      mode;
    logic [15:0]          noise;
    logic [3:0][15:0]     aud_l, aud_r;
    logic [1:0][15:0]     sil_lvl;
    logic [1:0][7:0]      sil_hold, aph_hold, mono_hold;
    logic [1:0][6:0]      aph_thr, mono_thr;
    logic [1:0][9:0]      glitch;
    logic [3:0]           sil_f, aph_f, mono_f;
    logic [2:0]           prog;
    afm_pkg::afm_policy_t policy;
    int                   n_mismatch, cmp_count, cyc;
    afm_note_t            notes[$];
    wire  [17:0]          obs = {video_fault, sil_f, aph_f, mono_f, prog, prev};

    afm_av_source afm_av_source_i (.clk(clk), .rst(rst), .video_on(video_on),
        .contact(contact), .mode(mode), .noise(noise), .video_present(video_present),
        .frame_tick(frame_tick), .gpi(gpi), .audio_valid(audio_valid),
        .audio_left(aud_l), .audio_right(aud_r));
    afm_monitor_switch #(.SAMPLES_PER_SEC(8)) afm_monitor_switch_i (.clk(clk), .rst(rst),
        .video_present(video_present), .frame_tick(frame_tick), .gpi(gpi),
        .audio_valid(audio_valid), .audio_left(aud_l), .audio_right(aud_r),
        .silence_level(sil_lvl), .silence_hold_time(sil_hold), .antiphase_threshold(aph_thr),
        .antiphase_hold_time(aph_hold), .mono_threshold(mono_thr), .mono_hold_time(mono_hold),
        .video_glitch_ignore_time(glitch), .switch_policy(policy), .video_fault(video_fault),
        .silence_fault(sil_f), .antiphase_fault(aph_f), .mono_fault(mono_f),
        .program_route(prog), .preview_route(prev));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    // Note an expected masked state; exact notes are judged only at their deadline
    task automatic expect_obs(input logic [17:0] val, input logic [17:0] mask, input int n,
                              input bit exact);
        afm_note_t nt;
        nt.val = val;
        nt.mask = mask;
        nt.dl = cyc + n;
        nt.exact = exact;
        notes.push_back(nt);
        while (notes.size() > 0) @(posedge clk);
    endtask : expect_obs

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial noise = 16'hb3fe;
    always @(posedge clk) noise <= lfsr(noise);

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (notes.size() > 0) begin
            if ((!notes[0].exact && (obs & notes[0].mask) === notes[0].val)
                    || cyc >= notes[0].dl) begin
                check(obs & notes[0].mask, notes[0].val);
                void'(notes.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        if (cyc >= 40000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1; video_on = 2'h3; contact = 2'h0; mode = '0; cyc = 0;
        policy = afm_pkg::afm_auto_revert_primary;
        sil_lvl = {2{16'h0100}}; sil_hold = {8'h28, 8'h02};
        aph_hold = {2{8'h02}}; mono_hold = {2{8'h02}};
        aph_thr = {2{7'h5a}}; mono_thr = {2{7'h14}}; glitch = {10'h000, 10'h003};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        expect_obs(18'h00001, 18'h3ffff, 900, 1'b1);
        mode[0] <= 3'h3;
        expect_obs(18'h03000, 18'h03330, 1200, 1'b0);
        mode[0] <= 3'h0;
        expect_obs(18'h00000, 18'h03000, 1200, 1'b0);
        mode[1] <= 3'h3;
        expect_obs(18'h00000, 18'h0c000, 850, 1'b1);
        expect_obs(18'h0c000, 18'h0c000, 600, 1'b0);
        mode[1] <= 3'h0;
        expect_obs(18'h00000, 18'h0c000, 1200, 1'b0);
        mode[0] <= 3'h1;
        expect_obs(18'h00300, 18'h00330, 1200, 1'b0);
        mode[0] <= 3'h0;
        expect_obs(18'h00000, 18'h00300, 1200, 1'b0);
        mode[0] <= 3'h2;
        expect_obs(18'h00030, 18'h00330, 1200, 1'b0);
        mode[0] <= 3'h0;
        expect_obs(18'h00000, 18'h00030, 1200, 1'b0);
        aph_thr[0] <= 7'h32;
        mode[0] <= 3'h4;
        expect_obs(18'h00030, 18'h00330, 1200, 1'b0);
        expect_obs(18'h00030, 18'h00330, 600, 1'b1);
        mode[0] <= 3'h0;
        aph_thr[0] <= 7'h5a;
        expect_obs(18'h00000, 18'h00030, 1200, 1'b0);
        video_on[0] <= 1'b0;
        repeat (40) @(posedge clk);
        video_on[0] <= 1'b1;
        expect_obs(18'h00001, 18'h3000f, 100, 1'b1);
        video_on[0] <= 1'b0;
        expect_obs(18'h1000e, 18'h3000f, 200, 1'b0);
        video_on[0] <= 1'b1;
        expect_obs(18'h00001, 18'h3000f, 100, 1'b0);
        video_on[1] <= 1'b0;
        expect_obs(18'h20001, 18'h3000f, 60, 1'b0);
        video_on[1] <= 1'b1;
        contact <= 2'h2;
        expect_obs(18'h0000e, 18'h3000f, 60, 1'b0);
        video_on[0] <= 1'b0;
        contact <= 2'h1;
        expect_obs(18'h10001, 18'h3000f, 200, 1'b1);
        contact <= 2'h3;
        expect_obs(18'h1000e, 18'h3000f, 20, 1'b0);
        video_on[0] <= 1'b1;
        expect_obs(18'h00001, 18'h3000f, 100, 1'b0);
        policy <= afm_pkg::afm_gpi_driven_switching;
        contact <= 2'h2;
        expect_obs(18'h0000e, 18'h0000f, 20, 1'b0);
        contact <= 2'h0;
        expect_obs(18'h0000e, 18'h0000f, 20, 1'b1);
        contact <= 2'h1;
        video_on[0] <= 1'b0;
        expect_obs(18'h10001, 18'h3000f, 200, 1'b1);
        video_on[0] <= 1'b1;
        expect_obs(18'h00001, 18'h3000f, 100, 1'b0);
        policy <= afm_pkg::afm_auto_follow_live;
        contact <= 2'h0;
        expect_obs(18'h00001, 18'h3000f, 20, 1'b1);
        video_on[0] <= 1'b0;
        expect_obs(18'h1000e, 18'h3000f, 200, 1'b0);
        video_on[0] <= 1'b1;
        expect_obs(18'h0000e, 18'h3000f, 200, 1'b1);
        video_on[1] <= 1'b0;
        expect_obs(18'h20001, 18'h3000f, 100, 1'b0);
        final_report();
    end
endmodule : afm_monitor_switch_bench
